// >>> logic/lcd_timing_pkg.sv
// Package with constants and carrier types of the LCD display timing generator.
package lcd_timing_pkg;

   // ------------------------------------------------------------------
   // Geometry
   // ------------------------------------------------------------------
   localparam int ROW_BITS       = 132;
   localparam int SEG_OUTS       = 133;
   localparam int START_BITS     = 6;
   localparam int PWR_BITS       = 3;

   // ------------------------------------------------------------------
   // Power control field positions and reset value
   // ------------------------------------------------------------------
   localparam int PWR_BOOST_BIT  = 2;
   localparam int PWR_REG_BIT    = 1;
   localparam int PWR_FOLLOW_BIT = 0;
   localparam logic [2:0] PWR_RESET = 3'h0;

   // ------------------------------------------------------------------
   // Timing defaults
   // ------------------------------------------------------------------
   localparam int DEF_LINE_DIV   = 8;
   localparam int DEF_FRAME_LINES = 33;
   localparam int SYNC_STAGES    = 3;

   // Drive level selection per segment: one of four levels.
   typedef enum logic [1:0] {
      LVL_V0,
      LVL_V2,
      LVL_V3,
      LVL_V5
   } drive_level_t;

   // Display output path controls.
   typedef struct packed {
      logic reverse;
      logic display_on;
      logic all_on;
   } disp_ctrl_t;

   // Link pins between master and slave chips.
   typedef struct packed {
      logic line_clock;
      logic ac_polarity;
      logic display_off_signal;
   } link_pins_t;

endpackage : lcd_timing_pkg

// >>> logic/lcd_display_timing_generator.sv
// Display timing generator: line clock, polarity, scan start, latch, power.
//
// What this block does
// [R1] Line clock drives line counter and latch
// [R2] RAM line address follows line clock
// [R3] Latch full 132-bit row per line
// [R4] Refresh reads independent of host accesses
// [R5] Polarity toggles every second frame, four-frame period
// [R6] Line clock divided from oscillator, driven out
// [R7] Scan start pulse when polarity switches
// [R8] Scan start driven only in master
// [R9] Slave takes polarity and line clock inputs
// [R10] Master outputs link, slave inputs them
// [R11] Latch holds row one common period
// [R12] Display controls act on output only
// [R13] 133 segments select four drive levels
// [R14] Oscillator runs only in master mode
// [R15] Power supply usable only in master
// [R16] Power bits enable booster, regulator, follower
// [R17] Host uses practical power codes
// [R18] Oscillator runs while booster enabled
// [R19] Polarity change presets counter from start
// [R20] Division and frame lines are parameters
`timescale 1ns/100ps
module lcd_display_timing_generator
   import lcd_timing_pkg::*;
#(
   parameter int LINE_DIV    = DEF_LINE_DIV,     // [R20]
   parameter int FRAME_LINES = DEF_FRAME_LINES   // [R20]
) (
   input  wire logic                  core_clk_i,
   input  wire logic                  rst_i,
   input  wire logic                  clk_en_i,
   input  wire logic                  master_mode_i,
   input  wire logic [PWR_BITS-1:0]   power_wdata_i,
   input  wire logic                  power_we_i,
   input  wire logic [START_BITS-1:0] start_line_i,
   input  wire disp_ctrl_t            disp_ctrl_i,
   input  wire logic [ROW_BITS-1:0]   ram_row_data_i,
   input  wire logic                  line_clock_i,
   input  wire logic                  ac_polarity_i,
   input  wire logic                  display_off_signal_i,
   input  wire logic [5:0]            common_index_i,
   output logic [START_BITS-1:0]      ram_line_addr_o,
   output logic                       line_clock_o,
   output logic                       line_clock_oe_o,
   output logic                       ac_polarity_o,
   output logic                       ac_polarity_oe_o,
   output logic                       display_off_signal_o,
   output logic                       display_off_signal_oe_o,
   output logic                       common_scan_start_o,
   output logic                       common_scan_start_oe_o,
   output logic                       common_select_o,
   output drive_level_t [SEG_OUTS-1:0] segment_output_o,
   output logic                       osc_enable_o,
   output logic                       booster_en_o,
   output logic                       regulator_en_o,
   output logic                       follower_en_o
);

   localparam int DIV_W = $clog2(LINE_DIV + 1);
   localparam int LIN_W = $clog2(FRAME_LINES + 1);
   localparam logic [DIV_W-1:0] HALF_DIV = DIV_W'(LINE_DIV / 2 - 1);
   localparam logic [DIV_W-1:0] LAST_DIV = DIV_W'(LINE_DIV - 1);
   localparam logic [LIN_W-1:0] LAST_LINE = LIN_W'(FRAME_LINES - 1);

   // ------------------------------------------------------------------
   // Power control register
   // ------------------------------------------------------------------
   logic [PWR_BITS-1:0] power_ff;
   logic [PWR_BITS-1:0] nxt_power;

   always_comb begin
      nxt_power = power_ff;
      if (power_we_i) begin
         nxt_power = power_wdata_i;
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         power_ff <= PWR_RESET;
      end else if (clk_en_i) begin
         power_ff <= nxt_power;
      end
   end

   assign booster_en_o   = master_mode_i & power_ff[PWR_BOOST_BIT];  // [R16] [R15]
   assign regulator_en_o = master_mode_i & power_ff[PWR_REG_BIT];    // [R16] [R15]
   assign follower_en_o  = master_mode_i & power_ff[PWR_FOLLOW_BIT]; // [R16] [R15]
   // The oscillator feeds both display timing and the booster.
   assign osc_enable_o   = master_mode_i;                            // [R14] [R18]

   // ------------------------------------------------------------------
   // Master timing: line clock divider, frame and polarity
   // ------------------------------------------------------------------
   logic [DIV_W-1:0] div_ff;
   logic [DIV_W-1:0] nxt_div;
   logic [LIN_W-1:0] line_ff;
   logic [LIN_W-1:0] nxt_line;
   logic [1:0]       frame_ff;
   logic [1:0]       nxt_frame;
   logic             mclk_ff;
   logic             nxt_mclk;
   logic             mpol_ff;
   logic             nxt_mpol;

   always_comb begin
      nxt_div   = div_ff;
      nxt_line  = line_ff;
      nxt_frame = frame_ff;
      nxt_mclk  = mclk_ff;
      nxt_mpol  = mpol_ff;
      if (!master_mode_i) begin
         nxt_div  = '0;
         nxt_mclk = 1'b0;
      end else if (div_ff == LAST_DIV) begin                  // [R6]
         nxt_div  = '0;
         nxt_mclk = 1'b0;
         if (line_ff == LAST_LINE) begin
            nxt_line  = '0;
            nxt_frame = frame_ff + 2'h1;
            if (frame_ff[0]) begin
               nxt_mpol = ~mpol_ff;                           // [R5]
            end
         end else begin
            nxt_line = line_ff + LIN_W'(1);
         end
      end else begin
         nxt_div = div_ff + DIV_W'(1);
         if (div_ff == HALF_DIV) begin
            nxt_mclk = 1'b1;                                  // [R6]
         end
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_ff   <= '0;
         line_ff  <= '0;
         frame_ff <= 2'h0;
         mclk_ff  <= 1'b0;
         mpol_ff  <= 1'b0;
      end else if (clk_en_i) begin
         div_ff   <= nxt_div;
         line_ff  <= nxt_line;
         frame_ff <= nxt_frame;
         mclk_ff  <= nxt_mclk;
         mpol_ff  <= nxt_mpol;
      end
   end

   // ------------------------------------------------------------------
   // Link pins and slave synchronisers
   // ------------------------------------------------------------------
   logic [SYNC_STAGES-1:0] pol_sync_ff;
   logic [SYNC_STAGES-1:0] dof_sync_ff;
   logic                   spol_ff;
   logic                   sdof_ff;
   logic                   nxt_spol;
   logic                   nxt_sdof;

   always_comb begin
      nxt_spol = spol_ff;
      nxt_sdof = sdof_ff;
      if (pol_sync_ff[2] == pol_sync_ff[1]) begin
         nxt_spol = pol_sync_ff[1];
      end
      if (dof_sync_ff[2] == dof_sync_ff[1]) begin
         nxt_sdof = dof_sync_ff[1];
      end
   end

   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         pol_sync_ff <= '0;
         dof_sync_ff <= '0;
         spol_ff     <= 1'b0;
         sdof_ff     <= 1'b0;
      end else if (clk_en_i) begin
         pol_sync_ff <= {pol_sync_ff[1:0], ac_polarity_i};
         dof_sync_ff <= {dof_sync_ff[1:0], display_off_signal_i};
         spol_ff     <= nxt_spol;
         sdof_ff     <= nxt_sdof;
      end
   end

   assign line_clock_o            = mclk_ff;                        // [R6]
   assign line_clock_oe_o         = master_mode_i;                  // [R9] [R10]
   assign ac_polarity_o           = mpol_ff;
   assign ac_polarity_oe_o        = master_mode_i;                  // [R9] [R10]
   assign display_off_signal_o    = ~disp_ctrl_i.display_on;
   assign display_off_signal_oe_o = master_mode_i;                  // [R10]

   // Line domain clock: own divider in master, the pin in slave.
   logic lclk;
   assign lclk = master_mode_i ? mclk_ff : line_clock_i;            // [R9]

   // Polarity and display-off used at the line logic.
   logic pol_core;
   logic dof_core;
   assign pol_core = master_mode_i ? mpol_ff : spol_ff;
   assign dof_core = master_mode_i ? ~disp_ctrl_i.display_on : sdof_ff;

   // ------------------------------------------------------------------
   // Line domain: counter, latch, scan start
   // ------------------------------------------------------------------
   logic [1:0]              lpol_sync_ff;
   logic                    lpol_ff;
   logic [START_BITS-1:0]   addr_ff;
   logic [START_BITS-1:0]   nxt_addr;
   logic [ROW_BITS-1:0]     latch_ff;
   logic                    scan_ff;
   logic                    nxt_scan;

   always_comb begin
      nxt_scan = 1'b0;
      nxt_addr = addr_ff + START_BITS'(1);                   // [R19] [R2]
      if (lpol_sync_ff[1] != lpol_ff) begin
         nxt_addr = start_line_i;                            // [R19]
         nxt_scan = 1'b1;                                    // [R7]
      end
   end

   // The row is latched on the falling line clock edge so the pulse and
   // the address change trail the preceding line clock.
   always_ff @(negedge lclk or posedge rst_i) begin
      if (rst_i) begin
         lpol_sync_ff <= 2'h0;
         lpol_ff      <= 1'b0;
         addr_ff      <= '0;
         latch_ff     <= '0;
         scan_ff      <= 1'b0;
      end else begin
         lpol_sync_ff <= {lpol_sync_ff[0], pol_core};
         lpol_ff      <= lpol_sync_ff[1];
         addr_ff      <= nxt_addr;                           // [R1] [R2]
         latch_ff     <= ram_row_data_i;                     // [R1] [R3] [R4] [R11]
         scan_ff      <= nxt_scan;
      end
   end

   assign ram_line_addr_o        = addr_ff;                  // [R2]
   assign common_scan_start_o    = scan_ff;                  // [R7]
   assign common_scan_start_oe_o = master_mode_i;            // [R8]
   assign common_select_o        = (common_index_i == 6'(addr_ff));

   // ------------------------------------------------------------------
   // Segment drive level selection
   // ------------------------------------------------------------------
   function automatic drive_level_t seg_level(input logic on,
                                              input logic sel,
                                              input logic pol);
      if (on == sel) begin
         seg_level = pol ? LVL_V5 : LVL_V0;
      end else begin
         seg_level = pol ? LVL_V3 : LVL_V2;
      end
   endfunction : seg_level

   always_comb begin
      for (int i = 0; i < SEG_OUTS; i++) begin
         logic px;
         px = (i < ROW_BITS) ? latch_ff[i % ROW_BITS] : 1'b0;
         // Controls act on this copy only; the row itself is untouched.
         px = (px ^ disp_ctrl_i.reverse) | disp_ctrl_i.all_on; // [R12]
         px = px & ~dof_core;                                   // [R12]
         segment_output_o[i] = seg_level(px, 1'b1, pol_core);   // [R13]
      end
   end

endmodule : lcd_display_timing_generator

// >>> tb/lcd_timing_asserts.sv
// Port checker of the LCD display timing generator.
`timescale 1ns/100ps
module lcd_timing_asserts
   import lcd_timing_pkg::*;
#(
   parameter int LINE_DIV = DEF_LINE_DIV
) (
   input wire logic                  core_clk_i,
   input wire logic                  rst_i,
   input wire logic                  clk_en_i,
   input wire logic                  master_mode_i,
   input wire logic [PWR_BITS-1:0]   power_wdata_i,
   input wire logic                  power_we_i,
   input wire disp_ctrl_t            disp_ctrl_i,
   input wire logic [5:0]            common_index_i,
   input wire logic [START_BITS-1:0] ram_line_addr_o,
   input wire logic                  common_select_o,
   input wire logic                  line_clock_o,
   input wire logic                  line_clock_oe_o,
   input wire logic                  ac_polarity_o,
   input wire logic                  ac_polarity_oe_o,
   input wire logic                  display_off_signal_o,
   input wire logic                  display_off_signal_oe_o,
   input wire logic                  common_scan_start_o,
   input wire logic                  common_scan_start_oe_o,
   input wire logic                  osc_enable_o,
   input wire logic                  booster_en_o,
   input wire logic                  regulator_en_o,
   input wire logic                  follower_en_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   logic       lc_ff;
   logic [7:0] run_ff;
   logic       seen_ff;
   wire  [2:0] pwr = {booster_en_o, regulator_en_o, follower_en_o};
   // Counts enabled cycles that the line clock holds one level.
   always_ff @(posedge core_clk_i or posedge rst_i) begin
      if (rst_i) begin
         lc_ff   <= 1'b0;
         run_ff  <= 8'h00;
         seen_ff <= 1'b0;
      end else if (clk_en_i) begin
         lc_ff   <= line_clock_o;
         run_ff  <= (line_clock_o != lc_ff) ? 8'h01 : run_ff + 8'h01;
         seen_ff <= seen_ff | (line_clock_o != lc_ff);
      end
   end
   property p_scan_oe; common_scan_start_oe_o == master_mode_i; endproperty
   property p_link_oe; {line_clock_oe_o, ac_polarity_oe_o,
      display_off_signal_oe_o} == {3{master_mode_i}}; endproperty
   property p_osc; osc_enable_o == master_mode_i; endproperty
   property p_pwr_slave; !master_mode_i |-> pwr == 3'h0; endproperty
   property p_boost_osc; booster_en_o |-> osc_enable_o; endproperty
   property p_pwr_wr; master_mode_i && power_we_i && clk_en_i ##1
      master_mode_i |-> pwr == $past(power_wdata_i); endproperty
   property p_pwr_hold; $past(master_mode_i) && master_mode_i &&
      !($past(power_we_i) && $past(clk_en_i)) |-> $stable(pwr); endproperty
   property p_dof; master_mode_i |->
      display_off_signal_o == !disp_ctrl_i.display_on; endproperty
   property p_sel;
      common_select_o == (common_index_i == ram_line_addr_o); endproperty
   property p_scan; master_mode_i && $changed(ac_polarity_o) |->
      ##[0:40] common_scan_start_o; endproperty
   property p_half; master_mode_i && seen_ff && clk_en_i &&
      line_clock_o != lc_ff |-> run_ff == LINE_DIV / 2; endproperty
   a_scan_oe: assert property (p_scan_oe) else $error("scan oe");
   a_link_oe: assert property (p_link_oe) else $error("link oe");
   a_osc: assert property (p_osc) else $error("osc enable");
   a_pwr_slave: assert property (p_pwr_slave) else $error("slave pwr");
   a_boost_osc: assert property (p_boost_osc) else $error("boost");
   a_pwr_wr: assert property (p_pwr_wr) else $error("pwr write");
   a_pwr_hold: assert property (p_pwr_hold) else $error("pwr hold");
   a_dof: assert property (p_dof) else $error("display off");
   a_sel: assert property (p_sel) else $error("common select");
   a_scan: assert property (p_scan) else $error("scan pulse");
   a_half: assert property (p_half) else $error("line half");
   c_scan: cover property (master_mode_i && $rose(common_scan_start_o));
   c_wr: cover property (master_mode_i && power_we_i && clk_en_i);
   c_slave: cover property (!master_mode_i && ram_line_addr_o != 6'h00);
endmodule : lcd_timing_asserts
bind lcd_display_timing_generator lcd_timing_asserts #(
   .LINE_DIV(LINE_DIV)) u_chk (.*);

// >>> tb/link_master_model.sv
// Master chip model that feeds link timing to a slave device.
`timescale 1ns/100ps
module link_master_model #(
   parameter int LINES = 4
) (
   input  wire logic run_i,
   input  wire logic dof_i,
   output logic      line_clock_o,
   output logic      ac_polarity_o,
   output logic      display_off_signal_o
);
   int lines = 0;
   initial line_clock_o = 1'b0;
   initial ac_polarity_o = 1'b0;
   always begin
      wait (run_i);
      #3 line_clock_o = 1'b1;
      #3 line_clock_o = 1'b0;
      lines++;
      if (lines == 2 * LINES) begin
         lines = 0;
         ac_polarity_o = ~ac_polarity_o;
      end
   end
   assign display_off_signal_o = dof_i;
endmodule : link_master_model

// >>> tb/lcd_display_timing_generator_tb_top.sv
// Self-checking testbench of the LCD display timing generator.
`timescale 1ns/100ps
module lcd_display_timing_generator_tb_top;
   import lcd_timing_pkg::*;
   // Host keeps to the practical supply codes only.
   localparam logic [2:0] CODES [5] = '{3'h7, 3'h3, 3'h1, 3'h7, 3'h0};
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic clk_en_i = 1'b1;
   logic master_mode_i = 1'b1;
   logic [PWR_BITS-1:0] power_wdata_i = 3'h0;
   logic power_we_i = 1'b0;
   logic [START_BITS-1:0] start_line_i = 6'h2A;
   disp_ctrl_t disp_ctrl_i = 3'h2;
   logic [ROW_BITS-1:0] ram_row_data_i = {33{4'hA}};
   logic [5:0] common_index_i = 6'h2A;
   logic run = 1'b0;
   logic line_clock_i, ac_polarity_i, display_off_signal_i;
   logic [START_BITS-1:0] ram_line_addr_o;
   logic line_clock_o, line_clock_oe_o, ac_polarity_o, ac_polarity_oe_o;
   logic display_off_signal_o, display_off_signal_oe_o, common_select_o;
   logic common_scan_start_o, common_scan_start_oe_o, osc_enable_o;
   logic booster_en_o, regulator_en_o, follower_en_o;
   drive_level_t [SEG_OUTS-1:0] segment_output_o;
   int mismatches = 0;
   int comparisons = 0;
   lcd_display_timing_generator #(.LINE_DIV(4), .FRAME_LINES(4)) DUT (.*);
   link_master_model #(.LINES(4)) u_far (.run_i(run), .dof_i(1'b0),
      .line_clock_o(line_clock_i), .ac_polarity_o(ac_polarity_i),
      .display_off_signal_o(display_off_signal_i));
   always #5 core_clk_i = ~core_clk_i;
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic step(input int n);
      repeat (n) @(posedge core_clk_i);
      #1;
   endtask : step
   task automatic pwr_wr(input logic [2:0] d, input logic en);
      power_wdata_i = d;
      power_we_i = 1'b1;
      clk_en_i = en;
      step(1);
      power_we_i = 1'b0;
      clk_en_i = 1'b1;
   endtask : pwr_wr
   task automatic do_reset(input logic m);
      rst_i = 1'b1;
      master_mode_i = m;
      step(20);
      rst_i = 1'b0;
      step(1);
   endtask : do_reset
   task automatic watch(input logic m);
      int pulses;
      int hits;
      pulses = 0;
      hits = 0;
      repeat (400) begin
         step(1);
         pulses += (common_scan_start_o === 1'b1 &&
                    common_scan_start_oe_o === 1'b1);
         if (ram_line_addr_o === start_line_i && common_select_o === 1'b1)
            hits++;
      end
      chk(8'(pulses > 0), {7'h00, m});
      chk(8'(hits > 0), 8'h01);
   endtask : watch
   task automatic wrap_up;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : wrap_up
   initial begin
      #60000;
      mismatches++;
      wrap_up();
   end
   initial begin
      do_reset(1'b1);
      chk({common_scan_start_oe_o, line_clock_oe_o, ac_polarity_oe_o,
         display_off_signal_oe_o, osc_enable_o}, 8'h1F);
      chk({booster_en_o, regulator_en_o, follower_en_o}, 8'h00);
      foreach (CODES[i]) begin
         pwr_wr(CODES[i], 1'b1);
         chk({booster_en_o, regulator_en_o, follower_en_o}, CODES[i]);
      end
      pwr_wr(3'h7, 1'b0);
      chk({booster_en_o, regulator_en_o, follower_en_o}, 8'h00);
      disp_ctrl_i.display_on = 1'b0;
      step(1);
      chk(display_off_signal_o, 8'h01);
      disp_ctrl_i.display_on = 1'b1;
      watch(1'b1);
      chk(segment_output_o[1], ac_polarity_o ? LVL_V5 : LVL_V0);
      chk(segment_output_o[0], ac_polarity_o ? LVL_V3 : LVL_V2);
      chk(segment_output_o[132], ac_polarity_o ? LVL_V3 : LVL_V2);
      disp_ctrl_i.all_on = 1'b1;
      step(1);
      chk(segment_output_o[0], ac_polarity_o ? LVL_V5 : LVL_V0);
      disp_ctrl_i.all_on = 1'b0;
      do_reset(1'b0);
      run = 1'b1;
      pwr_wr(3'h7, 1'b1);
      chk({booster_en_o, regulator_en_o, follower_en_o}, 8'h00);
      chk({common_scan_start_oe_o, line_clock_oe_o,
         ac_polarity_oe_o, osc_enable_o}, 8'h00);
      watch(1'b0);
      run = 1'b0;
      wrap_up();
   end
endmodule : lcd_display_timing_generator_tb_top
